// *** rtl/gpt_timer64.v ***
// Top module of the 64-bit general-purpose timer with Wishbone slave
`timescale 1ns/100ps
`include "gpt_consts.vh"
module gpt_timer64 #(
    parameter HAS_HIGH_EXT = 1
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [5:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    input  wire        low_half_clk_input_i,
    input  wire        high_half_clk_input_i,
    output reg         low_timer_out_o,
    output reg         high_timer_out_o,
    output reg         irq_o,
    output reg         dma_evt_o,
    output reg         running_o
);
    reg  [31:0] count_low_q;
    reg  [31:0] count_high_q;
    reg  [31:0] period_low_q;
    reg  [31:0] period_high_q;
    reg  [31:0] timer_control_q;
    reg  [31:0] global_control_q;
    reg  [31:0] count_shadow_q;
    reg         int_mask_q;
    reg         high_match_q;
    reg         once_done_q;
    reg         high_wrap_q;
    wire        low_ext_rise;
    wire        high_ext_rise;

    // Byte-lane merge for 32-bit writes
    function [31:0] lane_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel_v;
        integer k;
        begin
            lane_merge = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel_v[k]) begin
                    lane_merge[8*k +: 8] = new_v[8*k +: 8];
                end
            end
        end
    endfunction

    // Input clock qualifier from a select bit
    function tick_sel;
        input clk_sel;
        input ext_rise;
        begin
            tick_sel = clk_sel ? ext_rise : 1'b1;
        end
    endfunction

    gpt_ext_clk_edge u_low_edge (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .pin_i  (low_half_clk_input_i),
        .rise_o (low_ext_rise)
    );

    // Instance b has no upper external input
    generate
        if (HAS_HIGH_EXT != 0) begin : g_high_ext
            gpt_ext_clk_edge u_high_edge (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .ce_i   (ce_i),
                .pin_i  (high_half_clk_input_i),
                .rise_o (high_ext_rise)
            );
        end else begin : g_no_high_ext
            assign high_ext_rise = 1'b0;
        end
    endgenerate

    wire [1:0] timer_mode_field = global_control_q[`GPT_GCR_MODE_LSB +: 2];
    wire       low_run_n_reset  = global_control_q[`GPT_GCR_LOW_RS_BIT];
    wire       high_run_n_reset = global_control_q[`GPT_GCR_HIGH_RS_BIT];
    wire [1:0] low_enable_mode  = timer_control_q[`GPT_TCR_LOW_ENA_LSB +: 2];
    wire [1:0] high_enable_mode = timer_control_q[`GPT_TCR_HIGH_ENA_LSB +: 2];
    wire       low_clk_select   = timer_control_q[`GPT_TCR_LOW_CLK_BIT];
    wire       high_clk_select  = timer_control_q[`GPT_TCR_HIGH_CLK_BIT];
    wire       unchained        = (timer_mode_field == `GPT_MODE_UNCHAINED);
    wire       mode64           = (timer_mode_field == `GPT_MODE_64BIT);

    // Low clock-source bit governs whole timer unless unchained
    wire low_tick  = tick_sel(low_clk_select, low_ext_rise);
    wire high_tick = unchained ? tick_sel(high_clk_select, high_ext_rise) : low_tick;

    // 64-bit concatenation of counter and period
    wire [63:0] count64  = {count_high_q, count_low_q};
    wire [63:0] period64 = {period_high_q, period_low_q};
    wire        match64  = (count64 == period64);
    wire        in_reset = ~(low_run_n_reset & high_run_n_reset);
    wire        low_match  = (count_low_q == period_low_q);
    wire        high_match = (count_high_q == period_high_q);

    // Upper enable ignored outside unchained mode
    wire enabled   = (low_enable_mode != `GPT_ENA_OFF) && !once_done_q;
    wire zero_idle = (count64 == 64'h0) && (period64 == 64'h0);
    wire count_ok  = mode64 && !in_reset && enabled && low_tick && !zero_idle;
    wire high_en   = unchained && high_run_n_reset && (high_enable_mode != `GPT_ENA_OFF);
    wire high_ok   = high_en && high_tick && !high_wrap_q;

    wire        bus_req  = cyc_i & stb_i & ~ack_o;
    wire        bus_wr   = bus_req & we_i;
    wire        bus_rd   = bus_req & ~we_i;
    wire [3:0]  word_adr = adr_i[5:2];
    wire [63:0] count_inc = count64 + 64'h1;

    // Counter, match and pulse logic
    always @(posedge clk_i) begin
        if (rst_i) begin
            count_low_q  <= 32'h0;
            count_high_q <= 32'h0;
            once_done_q  <= 1'b0;
            high_wrap_q  <= 1'b0;
            high_match_q <= 1'b0;
            irq_o        <= 1'b0;
            dma_evt_o    <= 1'b0;
            low_timer_out_o  <= 1'b0;
            high_timer_out_o <= 1'b0;
            running_o    <= 1'b0;
        end else if (ce_i) begin
            irq_o        <= 1'b0;
            dma_evt_o    <= 1'b0;
            high_match_q <= 1'b0;
            running_o    <= count_ok;
            if (low_enable_mode == `GPT_ENA_OFF) begin
                once_done_q <= 1'b0;
            end
            if (in_reset) begin
                count_low_q  <= 32'h0;
                count_high_q <= 32'h0;
                once_done_q  <= 1'b0;
                high_wrap_q  <= 1'b0;
            end else if (mode64) begin
                if (bus_wr && word_adr == `GPT_ADR_COUNT_LOW) begin
                    count_low_q <= lane_merge(count_low_q, dat_i, sel_i);
                end else if (bus_wr && word_adr == `GPT_ADR_COUNT_HIGH) begin
                    count_high_q <= lane_merge(count_high_q, dat_i, sel_i);
                end else if (count_ok) begin
                    if (match64) begin
                        // Single-cycle pulse per match
                        irq_o     <= int_mask_q;
                        dma_evt_o <= 1'b1;
                        if (low_enable_mode == `GPT_ENA_CONT) begin
                            // Next tick after reaching period reads 0
                            count_low_q  <= 32'h0;
                            count_high_q <= 32'h0;
                        end else begin
                            once_done_q <= 1'b1;
                        end
                    end else begin
                        count_low_q  <= count_inc[31:0];
                        count_high_q <= count_inc[63:32];
                    end
                end
                low_timer_out_o <= count_ok && match64;
                high_timer_out_o <= 1'b0;
            end else begin
                // Upper half runs alone only when unchained
                if (unchained && high_ok) begin
                    if (high_match) begin
                        high_match_q <= 1'b1;
                        count_high_q <= (high_enable_mode == `GPT_ENA_CONT) ?
                                        32'h0 : count_high_q;
                        high_wrap_q  <= (high_enable_mode != `GPT_ENA_CONT);
                    end else begin
                        count_high_q <= count_high_q + 32'h1;
                    end
                end
                high_timer_out_o <= unchained & high_match_q;
                low_timer_out_o  <= 1'b0;
                if (high_enable_mode == `GPT_ENA_OFF) begin
                    high_wrap_q <= 1'b0;
                end
            end
        end
    end

    // Register file and shadow capture
    always @(posedge clk_i) begin
        if (rst_i) begin
            period_low_q     <= 32'h0;
            period_high_q    <= 32'h0;
            timer_control_q  <= `GPT_TCR_RESET;
            global_control_q <= `GPT_GCR_RESET;
            int_mask_q       <= 1'b0;
            count_shadow_q   <= 32'h0;
            dat_o            <= 32'h0;
            ack_o            <= 1'b0;
        end else if (ce_i) begin
            ack_o <= bus_req;
            dat_o <= 32'h0;
            if (bus_wr) begin
                case (word_adr)
                    `GPT_ADR_PERIOD_LOW:  period_low_q  <=
                        lane_merge(period_low_q, dat_i, sel_i);
                    `GPT_ADR_PERIOD_HIGH: period_high_q <=
                        lane_merge(period_high_q, dat_i, sel_i);
                    `GPT_ADR_TCR: timer_control_q <=
                        lane_merge(timer_control_q, dat_i, sel_i);
                    `GPT_ADR_GCR: global_control_q <=
                        lane_merge(global_control_q, dat_i, sel_i);
                    `GPT_ADR_INTMASK: if (sel_i[0]) int_mask_q <= dat_i[0];
                    default: ;
                endcase
            end
            if (bus_rd) begin
                case (word_adr)
                    `GPT_ADR_ID:          dat_o <= `GPT_ID_VALUE;
                    `GPT_ADR_COUNT_LOW: begin
                        dat_o <= count_low_q;
                        count_shadow_q <= count_high_q;
                    end
                    `GPT_ADR_COUNT_HIGH:  dat_o <= mode64 ? count_shadow_q
                                                          : count_high_q;
                    `GPT_ADR_PERIOD_LOW:  dat_o <= period_low_q;
                    `GPT_ADR_PERIOD_HIGH: dat_o <= period_high_q;
                    `GPT_ADR_TCR:         dat_o <= timer_control_q;
                    `GPT_ADR_GCR:         dat_o <= global_control_q;
                    `GPT_ADR_INTMASK:     dat_o <= {31'h0, int_mask_q};
                    default:              dat_o <= 32'h0;
                endcase
            end
        end
    end

    wire unused_low_match = low_match;
endmodule // gpt_timer64

// *** common/gpt_consts.vh ***
// Constants for the 64-bit general-purpose timer block
// Functional notes
// - Clock-source bit 0 selects internal clock, 1 selects synchronized external pin.
// - After reset both halves select the internal clock.
// - In 64-bit and chained mode the low clock-source bit governs all; unchained per half.
// - Instance a has two external clock inputs; instance b has one, lower half only.
// - Lower half drives timer output (the code drives it in 64-bit mode only, 0 otherwise); upper outputs only active in unchained mode.
// - Global mode field 0 selects single 64-bit timer; field resets to 0.
// - Counters and periods concatenate into one 64-bit counter and period.
// - While enabled the counter increments by 1 per selected input clock cycle.
// - Counter equal to period raises a maskable interrupt and a DMA sync event.
// - Continuous mode clears the counter to 0 the cycle after reaching the period.
// - Timer held in reset unless both half-reset bits are 1.
// - Enable 0 holds count, 1 counts to period once, 2h counts and wraps repeatedly.
// - In 64-bit mode only the lower enable field controls running.
// - External clock is synchronized; count value lives in the internal clock domain.
// - Counter and period both 0: enabling accepted but counter does not increment.
// - Reading low counter copies upper counter to shadow; upper read returns shadow in 64-bit mode, live upper counter otherwise.
`ifndef GPT_CONSTS_VH
`define GPT_CONSTS_VH
`define GPT_ADR_ID          4'h0
`define GPT_ADR_COUNT_LOW   4'h4
`define GPT_ADR_COUNT_HIGH  4'h5
`define GPT_ADR_PERIOD_LOW  4'h6
`define GPT_ADR_PERIOD_HIGH 4'h7
`define GPT_ADR_TCR         4'h8
`define GPT_ADR_GCR         4'h9
`define GPT_ADR_INTMASK     4'ha
`define GPT_ID_VALUE        32'h0000_5a01
`define GPT_TCR_LOW_ENA_LSB  6
`define GPT_TCR_LOW_CLK_BIT  8
`define GPT_TCR_HIGH_ENA_LSB 22
`define GPT_TCR_HIGH_CLK_BIT 24
`define GPT_TCR_RESET        32'h0000_0000
`define GPT_GCR_LOW_RS_BIT   0
`define GPT_GCR_HIGH_RS_BIT  1
`define GPT_GCR_MODE_LSB     2
`define GPT_GCR_RESET        32'h0000_0000
`define GPT_MODE_64BIT       2'h0
`define GPT_MODE_UNCHAINED   2'h1
`define GPT_ENA_OFF          2'h0
`define GPT_ENA_ONCE         2'h1
`define GPT_ENA_CONT         2'h2
`endif

// *** rtl/gpt_ext_clk_edge.v ***
// External clock pin synchronizer and rising-edge detector
`timescale 1ns/100ps
module gpt_ext_clk_edge (
    input  wire clk_i,
    input  wire rst_i,
    input  wire ce_i,
    input  wire pin_i,
    output reg  rise_o
);
    reg meta_q;
    reg sync_q;
    reg last_q;

    // Two flops before use, then edge detect
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            rise_o <= 1'b0;
        end else if (ce_i) begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            last_q <= sync_q;
            rise_o <= sync_q & ~last_q;
        end
    end
endmodule // gpt_ext_clk_edge

// *** verif/gpt_pin_model.sv ***
// Far-side model driving the external count clock pin
`timescale 1ns/100ps
module gpt_pin_model #(
    parameter int HALF_NS = 143
) (
    input  wire logic       go_i,
    input  wire logic [7:0] edges_i,
    output logic            pin_o
);
    // Pin rests low between bursts
    initial pin_o = 1'b0;
    always @(posedge go_i) begin
        repeat (edges_i) begin
            #HALF_NS pin_o = 1'b1;
            #HALF_NS pin_o = 1'b0;
        end
    end
endmodule // gpt_pin_model

// *** verif/gpt_timer64_asserts.sv ***
// Port checker for the 64-bit timer
`timescale 1ns/100ps
module gpt_timer64_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    input wire logic        irq_o,
    input wire logic        dma_evt_o,
    input wire logic        low_timer_out_o,
    input wire logic        running_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_ANSWER: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
        else $error("no ack after request");
    AST_ACK_DROP: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    AST_DMA_PULSE: assert property (dma_evt_o && ce_i |=> !dma_evt_o)
        else $error("dma event not a pulse");
    AST_IRQ_PULSE: assert property (irq_o && ce_i |=> !irq_o)
        else $error("irq not a pulse");
    AST_IRQ_MATCH: assert property (irq_o |-> dma_evt_o)
        else $error("irq without match event");
    AST_OUT_MATCH: assert property (dma_evt_o |-> low_timer_out_o)
        else $error("timer output missing on match");
    AST_CE_FREEZE: assert property (!ce_i |=> $stable(ack_o) && $stable(dat_o) && $stable(dma_evt_o))
        else $error("state moved with clock enable low");
    AST_RESET_QUIET: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !dma_evt_o && !running_o)
        else $error("outputs active after reset");
endmodule // gpt_timer64_asserts
bind gpt_timer64 gpt_timer64_asserts i_chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .ack_o,
    .dat_o, .irq_o, .dma_evt_o, .low_timer_out_o, .running_o);

// *** verif/gpt_timer64_bench.sv ***
// Self-checking bench for the 64-bit timer
`timescale 1ns/100ps
module gpt_timer64_bench;
    logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic        we_i = 1'b0, go = 1'b0, ack_o, low_half_clk_input_i, low_timer_out_o;
    logic        high_timer_out_o, irq_o, dma_evt_o, running_o;
    logic [5:0]  adr_i = 6'h0;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, q, v;
    logic [70:0] rows [10];
    int          failures = 0, compares = 0, cyc = 0, lastd = 0, gap = 0, ndma = 0, nirq = 0, n0;
    gpt_timer64 i_dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .low_half_clk_input_i, .high_half_clk_input_i(1'b0), .low_timer_out_o,
        .high_timer_out_o, .irq_o, .dma_evt_o, .running_o);
    gpt_pin_model i_pin (.go_i(go), .edges_i(8'h0c), .pin_o(low_half_clk_input_i));
    initial forever #20 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        {cyc_i, stb_i} <= 2'h0;
        chk(n < 50, 32'h1);
    endtask
    task final_report;
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (dma_evt_o === 1'b1) begin
            gap <= cyc - lastd;
            lastd <= cyc;
            ndma <= ndma + 1;
        end
        if (irq_o === 1'b1) nirq <= nirq + 1;
        if (cyc == 6000) begin
            failures++;
            final_report;
        end
    end
    initial begin
        rows = '{{1'b0, 6'h00, 32'h0, 32'h0000_5a01}, {1'b0, 6'h20, 32'h0, 32'h0},
                 {1'b0, 6'h24, 32'h0, 32'h0}, {1'b1, 6'h18, 32'h1234_5678, 32'h0},
                 {1'b0, 6'h18, 32'h0, 32'h1234_5678}, {1'b1, 6'h1c, 32'hab, 32'h0},
                 {1'b0, 6'h1c, 32'h0, 32'hab}, {1'b1, 6'h0c, 32'hffff_ffff, 32'h0},
                 {1'b0, 6'h0c, 32'h0, 32'h0}, {1'b1, 6'h28, 32'h1, 32'h0}};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i][70], rows[i][69:64], rows[i][63:32]);
            if (!rows[i][70]) chk(q, rows[i][31:0]);
        end
        bus(1'b1, 6'h24, 32'h3);
        bus(1'b1, 6'h18, 32'h14);
        bus(1'b1, 6'h1c, 32'h0);
        bus(1'b1, 6'h20, 32'h80);
        repeat (70) @(posedge clk_i);
        chk(gap, 32'h15);
        chk(nirq, ndma);
        ce_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        ce_i <= 1'b1;
        bus(1'b1, 6'h28, 32'h0);
        n0 = nirq;
        repeat (30) @(posedge clk_i);
        chk(nirq, n0);
        bus(1'b1, 6'h20, 32'h0);
        bus(1'b0, 6'h10, 32'h0);
        v = q;
        repeat (5) @(posedge clk_i);
        bus(1'b0, 6'h10, 32'h0);
        chk(q, v);
        bus(1'b1, 6'h24, 32'h0);
        bus(1'b1, 6'h24, 32'h3);
        bus(1'b1, 6'h18, 32'h9);
        bus(1'b1, 6'h20, 32'h40);
        n0 = ndma;
        repeat (40) @(posedge clk_i);
        chk(ndma, n0 + 1);
        bus(1'b0, 6'h10, 32'h0);
        chk(q, 32'h9);
        bus(1'b1, 6'h20, 32'h0);
        bus(1'b1, 6'h24, 32'h0);
        bus(1'b1, 6'h24, 32'h3);
        bus(1'b1, 6'h18, 32'h0);
        bus(1'b1, 6'h20, 32'h80);
        n0 = ndma;
        repeat (20) @(posedge clk_i);
        bus(1'b0, 6'h10, 32'h0);
        chk(q, 32'h0);
        chk(ndma, n0);
        bus(1'b1, 6'h24, 32'h1);
        bus(1'b1, 6'h18, 32'h32);
        bus(1'b0, 6'h10, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 6'h20, 32'h0180_0000);
        bus(1'b1, 6'h24, 32'h3);
        repeat (10) @(posedge clk_i);
        bus(1'b0, 6'h10, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 6'h20, 32'h0180_0080);
        repeat (10) @(posedge clk_i);
        bus(1'b0, 6'h10, 32'h0);
        chk(q > 32'h5, 32'h1);
        bus(1'b1, 6'h20, 32'h0);
        bus(1'b1, 6'h1c, 32'hff);
        bus(1'b1, 6'h14, 32'h2);
        bus(1'b1, 6'h10, 32'hffff_fff0);
        bus(1'b1, 6'h20, 32'h80);
        repeat (40) @(posedge clk_i);
        bus(1'b0, 6'h10, 32'h0);
        chk(q < 32'h40, 32'h1);
        bus(1'b1, 6'h14, 32'h9);
        bus(1'b0, 6'h14, 32'h0);
        chk(q, 32'h3);
        bus(1'b1, 6'h20, 32'h0);
        bus(1'b1, 6'h24, 32'h0);
        bus(1'b1, 6'h24, 32'h3);
        bus(1'b1, 6'h18, 32'h3e8);
        bus(1'b1, 6'h20, 32'h180);
        go <= 1'b1;
        repeat (100) @(posedge clk_i);
        bus(1'b0, 6'h10, 32'h0);
        chk(q, 32'hc);
        chk(high_timer_out_o, 32'h0);
        final_report;
    end
endmodule // gpt_timer64_bench
